/* File: cisl_core.sv */
// Function
// - Reset and the stack reload op set the stack index to top location.
// - Stack index decrements after each push, increments before each pull.
// - Stack addresses are fixed pattern 0000000011 plus six index bits.
// - Pushing past 64 bytes wraps the index silently, overwriting data.
// - A call pushes two bytes; interrupt entry pushes five.
// - A 16-bit next fetch address is always held.
// - An 8-bit index register feeds indexed addresses and scratch use.
// - Flag word has five bits: four result flags plus mask bit.
// - Half carry set on add when bit 3 carries into bit 4.
// - Negative and zero flags follow each result that has upd_nz set.
// - Carry follows ALU carry/borrow, bit tests, shifts and rotates.
// - Masked requests stay pending and are served once mask clears.
// - Entry stacks state and sets mask; return restores state.
// - Requests are taken at instruction end or at a soft trap, unmasked and enabled.
// - External request beats timer, serial and SPI requests.
// - Vectors by priority: reset, external, timer, serial, SPI.
// - Soft trap ignores the mask and vectors through its own pair.
// - Soft trap runs after requests pending at its fetch.
// - Falling edge on request line sets a latch served via its vector.
// - Port B pins with pullups act as extra external request lines.
// - Trigger sensitivity is edge-and-level or edge-only, per mode.
// - External latch clears early in entry so a new pulse is caught.
`timescale 1ns/1ns
`default_nettype none
module cisl_core (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire cisl_pkg::cisl_cmd_t cmd_i,
  input wire cisl_pkg::cisl_alu_t alu_i,
  input wire logic [7:0] acc_i,
  input wire logic instr_done_i,
  input wire logic fetch_i,
  input wire logic irq_line_n_i,
  input wire logic [7:0] portb_n_i,
  input wire logic [7:0] portb_pullup_i,
  input wire logic legacy_mode_i,
  input wire logic legacy_trigger_option_bit_i,
  input wire logic opt_trigger_bit_i,
  input wire cisl_pkg::cisl_periph_t periph_i,
  input wire logic [7:0] vec_data_i,
  output logic busy_o,
  output logic vec_rd_o,
  output logic [15:0] vec_addr_o,
  output logic [15:0] eff_addr_o,
  output logic line_low_o,
  output logic [7:0] acc_restore_o,
  output logic acc_load_o,
  output cisl_pkg::cisl_core_t core_o
);
  cisl_pkg::cisl_state_t st;
  cisl_pkg::cisl_state_t next_st;
  logic [7:0] mem_rdata;
  logic [7:0] push_data;
  logic mem_we;
  logic line_low;
  logic fall;
  logic ext_req;
  logic tmr_req;
  logic sci_req;
  logic spi_req;
  logic hw_any;
  logic edge_level;
  logic ext_clr;

  function automatic logic half_carry(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic [7:0] r);
    half_carry = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
  endfunction : half_carry

  function automatic logic [15:0] pick_vector(input logic e,
                                              input logic t,
                                              input logic s);
    if (e) begin
      pick_vector = cisl_pkg::VEC_EXT;
    end else if (t) begin
      pick_vector = cisl_pkg::VEC_TMR;
    end else if (s) begin
      pick_vector = cisl_pkg::VEC_SCI;
    end else begin
      pick_vector = cisl_pkg::VEC_SPI;
    end
  endfunction : pick_vector

  // Request line and port B pins with pullups share one trigger path.
  assign line_low = ~irq_line_n_i | (|(~portb_n_i & portb_pullup_i));
  assign fall = line_low & ~st.line_prev;
  assign edge_level = legacy_mode_i ? legacy_trigger_option_bit_i
                                    : opt_trigger_bit_i;
  assign ext_req = st.ext_latch | (edge_level & line_low);
  assign tmr_req = (periph_i.capture_event_flag & periph_i.capture_irq_enable)
    | (periph_i.compare_match_flag & periph_i.compare_irq_enable)
    | (periph_i.counter_wrap_flag & periph_i.counter_wrap_irq_enable);
  assign sci_req = (periph_i.tx_holding_empty_flag
                    & periph_i.tx_empty_irq_enable)
    | (periph_i.transmit_complete_flag & periph_i.tx_done_irq_enable)
    | ((periph_i.rx_holding_full_flag | periph_i.rx_overrun_flag)
       & periph_i.receive_irq_enable)
    | (periph_i.line_quiet_flag & periph_i.line_quiet_irq_enable);
  assign spi_req = (periph_i.transfer_done_flag | periph_i.fault_flag)
    & periph_i.serial_periph_irq_enable;
  assign hw_any = ext_req | tmr_req | sci_req | spi_req;

  always_comb begin
    case (st.cnt)
      3'h0: push_data = st.pc[7:0];
      3'h1: push_data = st.pc[15:8];
      3'h2: push_data = st.x;
      3'h3: push_data = acc_i;
      default: push_data = {3'h0, st.flags};
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.line_prev = line_low;
    next_st.a_load = 1'b0;
    ext_clr = 1'b0;
    if (fetch_i) begin
      next_st.snap_pend = hw_any;
    end
    case (st.fsm)
      cisl_pkg::S_IDLE: begin
        if (instr_done_i && hw_any && !st.flags[cisl_pkg::FLG_I]) begin
          // Taken only between instructions and only while unmasked.
          next_st.fsm = cisl_pkg::S_PUSH;
          next_st.cnt = 3'h0;
          next_st.is_irq = 1'b1;
          next_st.vec = pick_vector(ext_req, tmr_req, sci_req);
          ext_clr = ext_req;
        end else begin
          case (cmd_i.op)
            cisl_pkg::OP_INC_PC: next_st.pc = st.pc + 16'h0001;
            cisl_pkg::OP_JUMP: next_st.pc = cmd_i.addr;
            cisl_pkg::OP_LOAD_X: next_st.x = cmd_i.data;
            cisl_pkg::OP_STK_RELOAD: next_st.sp = cisl_pkg::SP_RESET;
            cisl_pkg::OP_SET_I: next_st.flags[cisl_pkg::FLG_I] = 1'b1;
            cisl_pkg::OP_CLR_I: next_st.flags[cisl_pkg::FLG_I] = 1'b0;
            cisl_pkg::OP_FLAGS: begin
              if (alu_i.upd_h) begin
                next_st.flags[cisl_pkg::FLG_H] =
                  half_carry(alu_i.opa, alu_i.opb, alu_i.res);
              end
              if (alu_i.upd_nz) begin
                next_st.flags[cisl_pkg::FLG_N] = alu_i.res[7];
                next_st.flags[cisl_pkg::FLG_Z] = alu_i.res == 8'h00;
              end
              if (alu_i.upd_c) begin
                next_st.flags[cisl_pkg::FLG_C] = alu_i.carry;
              end
            end
            cisl_pkg::OP_CALL: begin
              next_st.fsm = cisl_pkg::S_PUSH;
              next_st.cnt = 3'h0;
              next_st.is_irq = 1'b0;
              next_st.target = cmd_i.addr;
            end
            cisl_pkg::OP_TRAP_RET: begin
              next_st.fsm = cisl_pkg::S_PULL;
              next_st.cnt = 3'h0;
            end
            cisl_pkg::OP_SOFT_TRAP: begin
              next_st.fsm = cisl_pkg::S_PUSH;
              next_st.cnt = 3'h0;
              next_st.is_irq = 1'b1;
              if (!st.flags[cisl_pkg::FLG_I] && st.snap_pend && hw_any) begin
                // Stack the trap's own address so it reruns on return.
                next_st.pc = cmd_i.addr;
                next_st.vec = pick_vector(ext_req, tmr_req, sci_req);
                ext_clr = ext_req;
              end else begin
                next_st.vec = cisl_pkg::VEC_TRAP;
              end
            end
            default: ;
          endcase
        end
      end
      cisl_pkg::S_PUSH: begin
        next_st.sp = st.sp - 6'h01;
        next_st.cnt = st.cnt + 3'h1;
        if (st.cnt == (st.is_irq ? cisl_pkg::IRQ_LAST
                                 : cisl_pkg::CALL_LAST)) begin
          if (st.is_irq) begin
            next_st.fsm = cisl_pkg::S_VEC_HI;
            next_st.flags[cisl_pkg::FLG_I] = 1'b1;
          end else begin
            next_st.fsm = cisl_pkg::S_IDLE;
            next_st.pc = st.target;
          end
        end
      end
      cisl_pkg::S_VEC_HI: next_st.fsm = cisl_pkg::S_VEC_LO;
      cisl_pkg::S_VEC_LO: begin
        next_st.vec_hi = vec_data_i;
        next_st.fsm = cisl_pkg::S_VEC_END;
      end
      cisl_pkg::S_VEC_END: begin
        next_st.pc = {st.vec_hi, vec_data_i};
        next_st.fsm = cisl_pkg::S_IDLE;
      end
      cisl_pkg::S_PULL: begin
        next_st.sp = st.sp + 6'h01;
        next_st.fsm = cisl_pkg::S_PULL_DAT;
      end
      cisl_pkg::S_PULL_DAT: begin
        case (st.cnt)
          3'h0: next_st.flags = mem_rdata[4:0];
          3'h1: begin
            next_st.a_restore = mem_rdata;
            next_st.a_load = 1'b1;
          end
          3'h2: next_st.x = mem_rdata;
          3'h3: next_st.pc[15:8] = mem_rdata;
          default: next_st.pc[7:0] = mem_rdata;
        endcase
        next_st.cnt = st.cnt + 3'h1;
        next_st.fsm = (st.cnt == cisl_pkg::IRQ_LAST) ? cisl_pkg::S_IDLE
                                                     : cisl_pkg::S_PULL;
      end
      default: next_st.fsm = cisl_pkg::S_IDLE;
    endcase
    // A new edge in the clearing cycle survives.
    next_st.ext_latch = (st.ext_latch & ~ext_clr) | fall;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '{fsm: cisl_pkg::S_IDLE, cnt: 3'h0, pc: cisl_pkg::PC_RESET,
              x: 8'h00, sp: cisl_pkg::SP_RESET,
              flags: cisl_pkg::FLAGS_RESET, ext_latch: 1'b0,
              line_prev: 1'b1, snap_pend: 1'b0, target: 16'h0000,
              vec: cisl_pkg::VEC_RESET, vec_hi: 8'h00, is_irq: 1'b0,
              a_restore: 8'h00, a_load: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign mem_we = st.fsm == cisl_pkg::S_PUSH;

  cisl_stack_mem #(.AW(6), .DW(8)) u_mem (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .waddr_i(st.sp),
    .wdata_i(push_data),
    .raddr_i(st.sp + 6'h01),
    .rdata_o(mem_rdata)
  );

  assign busy_o = st.fsm != cisl_pkg::S_IDLE;
  assign vec_rd_o = (st.fsm == cisl_pkg::S_VEC_HI)
                  | (st.fsm == cisl_pkg::S_VEC_LO);
  assign vec_addr_o = (st.fsm == cisl_pkg::S_VEC_LO) ? st.vec + 16'h0001
                                                     : st.vec;
  assign eff_addr_o = cmd_i.addr + {8'h00, st.x};
  assign line_low_o = line_low;
  assign acc_restore_o = st.a_restore;
  assign acc_load_o = st.a_load;
  assign core_o = '{next_fetch_address: st.pc, index: st.x,
                    stack_index: st.sp, flag_word: st.flags,
                    stack_addr: {2'b00, cisl_pkg::STACK_HI, st.sp}};

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  logic idle;
  assign idle = st.fsm == cisl_pkg::S_IDLE;
  logic irq_take;
  assign irq_take = idle && instr_done_i && hw_any
                    && !st.flags[cisl_pkg::FLG_I];

  sp_reload_a: assert property (idle && !instr_done_i
    && cmd_i.op == cisl_pkg::OP_STK_RELOAD |=> st.sp == cisl_pkg::SP_RESET)
    else $error("stack index not reloaded");
  push_step_a: assert property (st.fsm == cisl_pkg::S_PUSH
    |=> st.sp == $past(st.sp) - 6'h01)
    else $error("push did not decrement stack index");
  stack_page_a: assert property (core_o.stack_addr[15:6] == 10'h003)
    else $error("stack address outside stack page");
  sp_wrap_a: assert property (st.fsm == cisl_pkg::S_PUSH
    && st.sp == 6'h00 |=> st.sp == 6'h3F)
    else $error("stack index did not wrap");
  entry_five_a: assert property (irq_take
    |=> (st.fsm == cisl_pkg::S_PUSH) [*5] ##1 st.fsm == cisl_pkg::S_VEC_HI
        && st.flags[cisl_pkg::FLG_I])
    else $error("entry did not push five bytes");
  call_two_a: assert property (idle && !irq_take
    && cmd_i.op == cisl_pkg::OP_CALL
    |=> (st.fsm == cisl_pkg::S_PUSH) [*2] ##1 idle)
    else $error("call did not push two bytes");
  mask_hold_a: assert property (idle && instr_done_i
    && st.flags[cisl_pkg::FLG_I] && cmd_i.op != cisl_pkg::OP_SOFT_TRAP
    && cmd_i.op != cisl_pkg::OP_CALL |=> idle)
    else $error("masked request was taken");
  ext_first_a: assert property (irq_take && ext_req
    |-> ##6 vec_rd_o && vec_addr_o == cisl_pkg::VEC_EXT)
    else $error("external request not served first");
  trap_vec_a: assert property (idle && !irq_take
    && cmd_i.op == cisl_pkg::OP_SOFT_TRAP && st.flags[cisl_pkg::FLG_I]
    |-> ##6 vec_addr_o == cisl_pkg::VEC_TRAP)
    else $error("soft trap used wrong vector");
  edge_latch_a: assert property (fall |=> st.ext_latch)
    else $error("falling edge not latched");
  vec_load_a: assert property (st.fsm == cisl_pkg::S_VEC_LO
    |=> ##1 st.pc == {$past(vec_data_i, 2), $past(vec_data_i)})
    else $error("vector bytes loaded in wrong order");

  entry_c: cover property (irq_take ##6 vec_rd_o);
  return_c: cover property (idle && cmd_i.op == cisl_pkg::OP_TRAP_RET
    ##10 idle);
  trap_c: cover property (idle && cmd_i.op == cisl_pkg::OP_SOFT_TRAP);
  wrap_c: cover property (st.fsm == cisl_pkg::S_PUSH && st.sp == 6'h00);
endmodule : cisl_core
`default_nettype wire

/* File: cisl_pkg.sv */
`default_nettype none
package cisl_pkg;
  localparam logic [5:0] SP_RESET = 6'h3F;
  localparam logic [7:0] STACK_HI = 8'h03;
  localparam logic [15:0] VEC_RESET = 16'h3FFE;
  localparam logic [15:0] VEC_TRAP = 16'h3FFC;
  localparam logic [15:0] VEC_EXT = 16'h3FFA;
  localparam logic [15:0] VEC_TMR = 16'h3FF8;
  localparam logic [15:0] VEC_SCI = 16'h3FF6;
  localparam logic [15:0] VEC_SPI = 16'h3FF4;
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  localparam logic [4:0] FLAGS_RESET = 5'h08;
  localparam logic [2:0] IRQ_LAST = 3'h4;
  localparam logic [2:0] CALL_LAST = 3'h1;
  localparam logic [15:0] PC_RESET = 16'h0000;

  typedef enum logic [3:0] {
    OP_NOP = 4'b0000, OP_INC_PC = 4'b0001, OP_JUMP = 4'b0010,
    OP_CALL = 4'b0011, OP_TRAP_RET = 4'b0100, OP_SOFT_TRAP = 4'b0101,
    OP_STK_RELOAD = 4'b0110, OP_LOAD_X = 4'b0111, OP_FLAGS = 4'b1000,
    OP_SET_I = 4'b1001, OP_CLR_I = 4'b1010
  } cisl_op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_PUSH = 3'b001, S_VEC_HI = 3'b010,
    S_VEC_LO = 3'b011, S_VEC_END = 3'b100, S_PULL = 3'b101,
    S_PULL_DAT = 3'b110
  } cisl_fsm_t;

  typedef struct packed {
    cisl_op_t op;
    logic [15:0] addr;
    logic [7:0] data;
  } cisl_cmd_t;

  typedef struct packed {
    logic upd_h;
    logic upd_nz;
    logic upd_c;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [7:0] res;
    logic carry;
  } cisl_alu_t;

  typedef struct packed {
    logic capture_event_flag;
    logic compare_match_flag;
    logic counter_wrap_flag;
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic counter_wrap_irq_enable;
    logic tx_holding_empty_flag;
    logic transmit_complete_flag;
    logic rx_holding_full_flag;
    logic rx_overrun_flag;
    logic line_quiet_flag;
    logic tx_empty_irq_enable;
    logic tx_done_irq_enable;
    logic receive_irq_enable;
    logic line_quiet_irq_enable;
    logic transfer_done_flag;
    logic fault_flag;
    logic serial_periph_irq_enable;
  } cisl_periph_t;

  typedef struct packed {
    logic [15:0] next_fetch_address;
    logic [7:0] index;
    logic [5:0] stack_index;
    logic [4:0] flag_word;
    logic [15:0] stack_addr;
  } cisl_core_t;

  typedef struct packed {
    cisl_fsm_t fsm;
    logic [2:0] cnt;
    logic [15:0] pc;
    logic [7:0] x;
    logic [5:0] sp;
    logic [4:0] flags;
    logic ext_latch;
    logic line_prev;
    logic snap_pend;
    logic [15:0] target;
    logic [15:0] vec;
    logic [7:0] vec_hi;
    logic is_irq;
    logic [7:0] a_restore;
    logic a_load;
  } cisl_state_t;
endpackage : cisl_pkg
`default_nettype wire

/* File: cisl_src_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cisl_src_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic vec_rd_i,
  input wire logic [15:0] vec_addr_i,
  input wire logic ext_low_i,
  input wire logic [7:0] pb_low_i,
  input wire logic [2:0] src_i,
  output logic irq_line_n_o,
  output logic [7:0] portb_n_o,
  output cisl_pkg::cisl_periph_t periph_o,
  output logic [7:0] vec_data_o
);
  // Released request pins are pulled high, so they idle at one.
  assign irq_line_n_o = !ext_low_i;
  assign portb_n_o = ~pb_low_i;

  // Each source raises one of its flags with its local enable set.
  always_comb begin
    periph_o = '0;
    periph_o.counter_wrap_flag = src_i[0];
    periph_o.counter_wrap_irq_enable = 1'h1;
    periph_o.rx_holding_full_flag = src_i[1];
    periph_o.receive_irq_enable = 1'h1;
    periph_o.transfer_done_flag = src_i[2];
    periph_o.serial_periph_irq_enable = 1'h1;
  end

  // Vector bytes follow from their address and are valid the cycle after
  // the strobe; otherwise the bus toggles so stale data never matches.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i)
      vec_data_o <= 8'h00;
    else if (vec_rd_i)
      vec_data_o <= vec_addr_i[7:0] + 8'h11;
    else
      vec_data_o <= ~vec_data_o;
  end
endmodule : cisl_src_model
`default_nettype wire

/* File: cisl_stack_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module cisl_stack_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0] rdata;
  } cisl_mem_st_t;

  cisl_mem_st_t st;
  cisl_mem_st_t next_st;

  // Read data is registered; a read in the cycle of a write sees old data.
  always_comb begin
    next_st = st;
    if (we_i) begin
      next_st.mem[waddr_i] = wdata_i;
    end
    next_st.rdata = st.mem[raddr_i];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
endmodule : cisl_stack_mem
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic sys_clk_i;
  logic rst_i;
  cisl_pkg::cisl_cmd_t cmd_i;
  cisl_pkg::cisl_alu_t alu_i;
  logic [7:0] acc_i;
  logic instr_done_i;
  logic fetch_i;
  logic irq_line_n;
  logic [7:0] portb_n;
  logic [7:0] pb_pullup;
  logic legacy_mode;
  logic legacy_bit;
  logic opt_bit;
  cisl_pkg::cisl_periph_t periph;
  logic [7:0] vec_data;
  logic busy_o;
  logic vec_rd_o;
  logic [15:0] vec_addr_o;
  logic [15:0] eff_addr_o;
  logic line_low_o;
  logic [7:0] acc_restore_o;
  logic acc_load_o;
  cisl_pkg::cisl_core_t core_o;
  logic ext_low;
  logic [7:0] pb_low;
  logic [2:0] src;
  int n_errors;
  int n_tests;
  int nb;
  logic [15:0] vseen;
  logic [7:0] aseen;
  localparam cisl_pkg::cisl_alu_t ALU_TAB [3] = '{
    {3'h7, 8'h0F, 8'h01, 8'h10, 1'h0}, {3'h7, 8'h80, 8'h80, 8'h00, 1'h1},
    {3'h7, 8'h78, 8'h08, 8'h80, 1'h0}};
  localparam logic [15:0] FLG_TAB [3] = '{16'h0018, 16'h000B, 16'h001C};
  localparam logic [2:0] SRC_TAB [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
  localparam logic [7:0] PB_TAB [4] = '{8'h00, 8'h00, 8'h00, 8'h04};
  localparam logic [15:0] VEC_TAB [4] = '{cisl_pkg::VEC_TMR,
    cisl_pkg::VEC_SCI, cisl_pkg::VEC_SPI, cisl_pkg::VEC_EXT};
  localparam logic [2:0] MODE_TAB [4] = '{3'h1, 3'h5, 3'h6, 3'h0};
  localparam logic [15:0] NB_TAB [4] = '{16'h0008, 16'h0000, 16'h0008,
    16'h0000};

  cisl_core uut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .alu_i(alu_i),
    .acc_i(acc_i), .instr_done_i(instr_done_i), .fetch_i(fetch_i),
    .irq_line_n_i(irq_line_n), .portb_n_i(portb_n),
    .portb_pullup_i(pb_pullup), .legacy_mode_i(legacy_mode),
    .legacy_trigger_option_bit_i(legacy_bit), .opt_trigger_bit_i(opt_bit),
    .periph_i(periph), .vec_data_i(vec_data), .busy_o(busy_o),
    .vec_rd_o(vec_rd_o), .vec_addr_o(vec_addr_o), .eff_addr_o(eff_addr_o),
    .line_low_o(line_low_o), .acc_restore_o(acc_restore_o),
    .acc_load_o(acc_load_o), .core_o(core_o));

  cisl_src_model partner (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .vec_rd_i(vec_rd_o),
    .vec_addr_i(vec_addr_o), .ext_low_i(ext_low), .pb_low_i(pb_low),
    .src_i(src), .irq_line_n_o(irq_line_n), .portb_n_o(portb_n),
    .periph_o(periph), .vec_data_o(vec_data));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [15:0] tgt(input logic [15:0] v);
    tgt = {v[7:0] + 8'h11, v[7:0] + 8'h12};
  endfunction : tgt

  // Issues one op, optionally at an instruction boundary, then counts the
  // busy cycles and notes the first vector address and any restored byte.
  task automatic run(input cisl_pkg::cisl_op_t o, input logic [15:0] a,
                     input logic [7:0] d, input logic done);
    @(posedge sys_clk_i);
    cmd_i <= '{o, a, d};
    fetch_i <= 1'h1;
    instr_done_i <= done;
    @(posedge sys_clk_i);
    cmd_i <= '{cisl_pkg::OP_NOP, 16'h0000, 8'h00};
    fetch_i <= 1'h0;
    instr_done_i <= 1'h0;
    nb = 0;
    vseen = 16'h0000;
    #1;
    while (busy_o !== 1'h0 && nb < 40) begin
      if (vec_rd_o === 1'h1 && vseen === 16'h0000)
        vseen = vec_addr_o;
      if (acc_load_o === 1'h1)
        aseen = acc_restore_o;
      nb++;
      @(posedge sys_clk_i);
      #1;
    end
  endtask : run

  task stop_test;
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  initial begin
    sys_clk_i = 1'h0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #100000;
    n_errors++;
    stop_test();
  end

  initial begin
    rst_i = 1'h1;
    cmd_i = '{cisl_pkg::OP_NOP, 16'h0000, 8'h00};
    alu_i = '0;
    acc_i = 8'h3C;
    instr_done_i = 1'h0;
    fetch_i = 1'h0;
    pb_pullup = 8'h04;
    {legacy_mode, legacy_bit, opt_bit} = 3'h0;
    ext_low = 1'h0;
    pb_low = 8'h00;
    src = 3'h0;
    n_errors = 0;
    n_tests = 0;
    aseen = 8'h00;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    #1;
    chk(core_o.next_fetch_address, cisl_pkg::PC_RESET);
    chk(16'(core_o.stack_index), 16'h003F);
    chk(core_o.stack_addr, 16'h00FF);
    chk(16'(core_o.flag_word), 16'h0008);
    run(cisl_pkg::OP_LOAD_X, 16'h0000, 8'hA5, 1'h0);
    chk(16'(core_o.index), 16'h00A5);
    @(posedge sys_clk_i);
    cmd_i <= '{cisl_pkg::OP_NOP, 16'h10FF, 8'h00};
    #1;
    chk(eff_addr_o, 16'h11A4);
    run(cisl_pkg::OP_JUMP, 16'h1234, 8'h00, 1'h0);
    run(cisl_pkg::OP_INC_PC, 16'h0000, 8'h00, 1'h0);
    chk(core_o.next_fetch_address, 16'h1235);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk_i);
      alu_i <= ALU_TAB[i];
      run(cisl_pkg::OP_FLAGS, 16'h0000, 8'h00, 1'h0);
      chk(16'(core_o.flag_word), FLG_TAB[i]);
    end
    run(cisl_pkg::OP_CALL, 16'h2000, 8'h00, 1'h0);
    chk(16'(nb), 16'h0002);
    chk(16'(core_o.stack_index), 16'h003D);
    repeat (32) run(cisl_pkg::OP_CALL, 16'h2000, 8'h00, 1'h0);
    chk(core_o.stack_addr, 16'h00FD);
    run(cisl_pkg::OP_STK_RELOAD, 16'h0000, 8'h00, 1'h0);
    chk(16'(core_o.stack_index), 16'h003F);
    @(posedge sys_clk_i);
    ext_low <= 1'h1;
    src <= 3'h1;
    repeat (3) @(posedge sys_clk_i);
    run(cisl_pkg::OP_NOP, 16'h0000, 8'h00, 1'h1);
    chk(16'(nb), 16'h0000);
    chk(16'(line_low_o), 16'h0001);
    ext_low <= 1'h0;
    run(cisl_pkg::OP_CLR_I, 16'h0000, 8'h00, 1'h0);
    run(cisl_pkg::OP_JUMP, 16'h0456, 8'h00, 1'h0);
    chk(16'(nb), 16'h0000);
    run(cisl_pkg::OP_NOP, 16'h0000, 8'h00, 1'h1);
    chk(16'(nb), 16'h0008);
    chk(vseen, cisl_pkg::VEC_EXT);
    chk(core_o.next_fetch_address, tgt(cisl_pkg::VEC_EXT));
    chk(16'(core_o.flag_word[cisl_pkg::FLG_I]), 16'h0001);
    chk(16'(core_o.stack_index), 16'h003A);
    src <= 3'h0;
    run(cisl_pkg::OP_TRAP_RET, 16'h0000, 8'h00, 1'h0);
    chk(16'(nb), 16'h000A);
    chk(core_o.next_fetch_address, 16'h0456);
    chk(16'(core_o.flag_word), 16'h0014);
    chk(16'(aseen), 16'h003C);
    chk(16'(core_o.stack_index), 16'h003F);
    run(cisl_pkg::OP_NOP, 16'h0000, 8'h00, 1'h1);
    chk(16'(nb), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      src <= SRC_TAB[i];
      pb_low <= PB_TAB[i];
      run(cisl_pkg::OP_CLR_I, 16'h0000, 8'h00, 1'h0);
      run(cisl_pkg::OP_NOP, 16'h0000, 8'h00, 1'h1);
      chk(vseen, VEC_TAB[i]);
      chk(core_o.next_fetch_address, tgt(VEC_TAB[i]));
      src <= 3'h0;
      pb_low <= 8'h00;
    end
    run(cisl_pkg::OP_SOFT_TRAP, 16'h0777, 8'h00, 1'h0);
    chk(vseen, cisl_pkg::VEC_TRAP);
    chk(core_o.next_fetch_address, tgt(cisl_pkg::VEC_TRAP));
    @(posedge sys_clk_i);
    src <= 3'h1;
    run(cisl_pkg::OP_CLR_I, 16'h0000, 8'h00, 1'h0);
    run(cisl_pkg::OP_SOFT_TRAP, 16'h0999, 8'h00, 1'h0);
    chk(vseen, cisl_pkg::VEC_TMR);
    src <= 3'h0;
    run(cisl_pkg::OP_TRAP_RET, 16'h0000, 8'h00, 1'h0);
    chk(core_o.next_fetch_address, 16'h0999);
    run(cisl_pkg::OP_SET_I, 16'h0000, 8'h00, 1'h0);
    chk(16'(core_o.flag_word[cisl_pkg::FLG_I]), 16'h0001);
    run(cisl_pkg::OP_CLR_I, 16'h0000, 8'h00, 1'h0);
    @(posedge sys_clk_i);
    ext_low <= 1'h1;
    repeat (3) @(posedge sys_clk_i);
    run(cisl_pkg::OP_NOP, 16'h0000, 8'h00, 1'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      {legacy_mode, legacy_bit, opt_bit} <= MODE_TAB[i];
      run(cisl_pkg::OP_CLR_I, 16'h0000, 8'h00, 1'h0);
      run(cisl_pkg::OP_NOP, 16'h0000, 8'h00, 1'h1);
      chk(16'(nb), NB_TAB[i]);
    end
    ext_low <= 1'h0;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
